// ==== src/sigma_adc_control_regs.v ====
// Register control, clock divider and decimator of the 16-bit converter
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/100ps
`include "adc_ctrl_map.vh"
module sigma_adc_control_regs (
  input wire clk, // System oscillator clock, 100 MHz
  input wire rst_b, // Synchronous reset, active low
  input wire psel, // APB select
  input wire penable, // APB access phase
  input wire pwrite, // APB write
  input wire [11:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output wire [31:0] prdata, // APB read data
  output wire pready, // APB ready
  output wire pslverr, // APB error on unmapped address
  input wire modulatorBit, // Modulator bitstream from analogue core
  output wire converterEnable, // Powers the converter
  output wire inputSourceSelect, // 0 amplifier, 1 supply detection
  output wire referenceSourceSelect, // 0 external, 1 internal
  output wire internalRefScale, // 0 small span, 1 double span
  output wire converterClock // Clock to the modulator
);

  // --------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------
  wire [9:0] wordIndex;
  wire aligned;
  wire hitMode;
  wire hitDivisor;
  wire hitStatus;
  wire hitLow;
  wire hitHigh;
  wire mapped;
  wire setupPhase;
  wire writeEn;

  assign wordIndex = paddr[11:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign hitMode = aligned && (wordIndex == `MODE_INDEX);
  assign hitDivisor = aligned && (wordIndex == `DIVISOR_INDEX);
  assign hitStatus = aligned && (wordIndex == `STATUS_INDEX);
  assign hitLow = aligned && (wordIndex == `RESULT_LOW_INDEX);
  assign hitHigh = aligned && (wordIndex == `RESULT_HIGH_INDEX);
  assign mapped = hitMode || hitDivisor || hitStatus || hitLow || hitHigh;
  assign setupPhase = psel && !penable;
  assign writeEn = psel && penable && pwrite && mapped;

  // Zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // --------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------
  reg [`MODE_WIDTH-1:0] mode_reg;
  reg [7:0] divisor_reg;
  reg rate_reg;

  always @(posedge clk) begin
    if (!rst_b) begin
      mode_reg <= `MODE_RESET;
      divisor_reg <= `DIVISOR_RESET;
      rate_reg <= `RATE_RESET;
    end else if (writeEn) begin
      if (hitMode) begin
        mode_reg <= pwdata[`MODE_WIDTH-1:0];
      end
      if (hitDivisor) begin
        divisor_reg <= pwdata[7:0];
      end
      if (hitStatus) begin
        rate_reg <= pwdata[`STATUS_RATE_BIT];
      end
    end
  end

  assign converterEnable = mode_reg[`MODE_ENABLE_BIT];
  assign inputSourceSelect = mode_reg[`MODE_INPUT_BIT];
  assign referenceSourceSelect = mode_reg[`MODE_REF_BIT];
  assign internalRefScale = mode_reg[`MODE_SCALE_BIT];

  // --------------------------------------------------------------------
  // Converter clock divider
  // --------------------------------------------------------------------
  // Half period of (256 - divisor) oscillator cycles, always 1..256
  wire [8:0] halfPeriod;
  reg [8:0] halfCount_reg;
  reg convClk_reg;
  wire halfDone;
  wire convTick;

  assign halfPeriod = `DIVIDE_BASE - {1'b0, divisor_reg};
  assign halfDone = (halfCount_reg >= halfPeriod - 9'h001);
  // One pulse per converter clock period, at its rising edge
  assign convTick = converterEnable && halfDone && !convClk_reg;

  always @(posedge clk) begin
    if (!rst_b || !converterEnable) begin
      halfCount_reg <= 9'h000;
      convClk_reg <= 1'b0;
    end else if (halfDone) begin
      halfCount_reg <= 9'h000;
      convClk_reg <= !convClk_reg;
    end else begin
      halfCount_reg <= halfCount_reg + 9'h001;
    end
  end

  assign converterClock = convClk_reg;

  // --------------------------------------------------------------------
  // Modulator input synchroniser
  // --------------------------------------------------------------------
  reg modSync1_reg;
  reg modSync2_reg;

  always @(posedge clk) begin
    if (!rst_b) begin
      modSync1_reg <= 1'b0;
      modSync2_reg <= 1'b0;
    end else begin
      modSync1_reg <= modulatorBit;
      modSync2_reg <= modSync1_reg;
    end
  end

  // --------------------------------------------------------------------
  // Decimator
  // --------------------------------------------------------------------
  // Counts ones over one word; ones minus zeros scales to +/-31250
  wire [12:0] wordLen;
  reg [12:0] sampleCount_reg;
  reg [12:0] onesCount_reg;
  reg [`RESULT_WIDTH-1:0] word_reg;
  reg wordValid_reg;
  wire fifoInReady;
  wire [12:0] onesFinal;
  wire wordEnd;
  wire signed [14:0] diff;
  wire signed [21:0] diffWide;
  wire signed [21:0] scaled;
  wire signed [21:0] shifted;
  wire takeTick;

  assign wordLen = rate_reg ? `WORD_LEN_SLOW : `WORD_LEN_FAST;
  // A pending word stalls counting until the buffer has room
  assign takeTick = convTick && !wordValid_reg;
  assign onesFinal = onesCount_reg + {12'h000, modSync2_reg};
  assign wordEnd = (sampleCount_reg == wordLen - 13'h0001);
  assign diff = $signed({1'b0, onesFinal, 1'b0})
              - $signed({2'h0, wordLen});
  assign diffWide = {{7{diff[14]}}, diff};
  // Times 125, then over 16 or 32: full ones gives 0x7A12
  assign scaled = (diffWide <<< 7) - (diffWide <<< 2) + diffWide;
  assign shifted = rate_reg ? (scaled >>> `SHIFT_SLOW)
                            : (scaled >>> `SHIFT_FAST);

  always @(posedge clk) begin
    if (!rst_b || !converterEnable) begin
      sampleCount_reg <= 13'h0000;
      onesCount_reg <= 13'h0000;
      word_reg <= `RESULT_RESET;
      wordValid_reg <= 1'b0;
    end else begin
      if (wordValid_reg && fifoInReady) begin
        wordValid_reg <= 1'b0;
      end
      if (takeTick) begin
        if (wordEnd) begin
          sampleCount_reg <= 13'h0000;
          onesCount_reg <= 13'h0000;
          word_reg <= shifted[`RESULT_WIDTH-1:0];
          wordValid_reg <= 1'b1;
        end else begin
          sampleCount_reg <= sampleCount_reg + 13'h0001;
          onesCount_reg <= onesFinal;
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Result buffer
  // --------------------------------------------------------------------
  wire fifoOutValid;
  wire [`RESULT_WIDTH-1:0] fifoOutData;
  wire loadResult;
  reg ready_reg;

  // Next word moves up only once software has cleared ready
  assign loadResult = fifoOutValid && !ready_reg;

  sample_fifo #(
    .WIDTH(`RESULT_WIDTH),
    .DEPTH(`FIFO_DEPTH),
    .ADDR_BITS(`FIFO_ADDR_BITS)
  ) sample_fifo_inst (
    .clk(clk),
    .rst_b(rst_b),
    .flush(!converterEnable),
    .inValid(wordValid_reg),
    .inReady(fifoInReady),
    .inData(word_reg),
    .outValid(fifoOutValid),
    .outReady(loadResult),
    .outData(fifoOutData)
  );

  // --------------------------------------------------------------------
  // Result and ready flag
  // --------------------------------------------------------------------
  reg [`RESULT_WIDTH-1:0] result_reg;
  wire readyClear;

  assign readyClear = writeEn && hitStatus && !pwdata[`STATUS_READY_BIT];

  always @(posedge clk) begin
    if (!rst_b) begin
      result_reg <= `RESULT_RESET;
      ready_reg <= `READY_RESET;
    end else begin
      if (loadResult) begin
        result_reg <= fifoOutData;
      end
      // Setting wins over a clear in the same cycle
      if (loadResult) begin
        ready_reg <= 1'b1;
      end else if (readyClear) begin
        ready_reg <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------
  reg [31:0] prdata_reg;
  reg [31:0] prdata_next;

  always @* begin
    prdata_next = 32'h00000000;
    if (hitMode) begin
      prdata_next = {27'h0000000, mode_reg};
    end else if (hitStatus) begin
      prdata_next = {29'h00000000, rate_reg, 1'b0, ready_reg};
    end else if (hitLow) begin
      prdata_next = {24'h000000, result_reg[7:0]};
    end else if (hitHigh) begin
      prdata_next = {24'h000000, result_reg[15:8]};
    end
  end

  // Captured in the setup cycle, stable through the access phase
  always @(posedge clk) begin
    if (!rst_b) begin
      prdata_reg <= 32'h00000000;
    end else if (setupPhase) begin
      prdata_reg <= prdata_next;
    end
  end

  assign prdata = prdata_reg;

endmodule // sigma_adc_control_regs

// ==== src/adc_ctrl_map.vh ====
// Register map, field positions, reset values and counts of the converter
`ifndef ADC_CTRL_MAP_VH
`define ADC_CTRL_MAP_VH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define MODE_INDEX 10'h093
`define DIVISOR_INDEX 10'h094
`define STATUS_INDEX 10'h097
`define RESULT_LOW_INDEX 10'h098
`define RESULT_HIGH_INDEX 10'h099

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define MODE_ENABLE_BIT 0
`define MODE_INPUT_BIT 1
`define MODE_REF_BIT 2
`define MODE_SCALE_BIT 3
`define MODE_WIDTH 5
`define STATUS_READY_BIT 0
`define STATUS_RATE_BIT 2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define MODE_RESET 5'h00
`define DIVISOR_RESET 8'h00
`define RESULT_RESET 16'h0000
`define READY_RESET 1'b0
`define RATE_RESET 1'b0

// ----------------------------------------------------------------------
// Converter clock and word timing
// ----------------------------------------------------------------------
`define DIVIDE_BASE 9'h100
`define WORD_LEN_FAST 13'h0FA0
`define WORD_LEN_SLOW 13'h1F40
`define SHIFT_FAST 4
`define SHIFT_SLOW 5

// ----------------------------------------------------------------------
// Result buffer
// ----------------------------------------------------------------------
`define RESULT_WIDTH 16
`define FIFO_DEPTH 8
`define FIFO_ADDR_BITS 3

`endif

// ==== src/sample_fifo.v ====
// Flip-flop FIFO with valid and ready on both sides
`timescale 1ns/100ps
module sample_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter ADDR_BITS = 3
) (
  input wire clk, // System clock
  input wire rst_b, // Synchronous reset, active low
  input wire flush, // Empties the buffer
  input wire inValid, // Word offered
  output wire inReady, // Room for a word
  input wire [WIDTH-1:0] inData, // Word written
  output wire outValid, // Word available
  input wire outReady, // Consumer takes the word
  output wire [WIDTH-1:0] outData // Oldest word
);

  // --------------------------------------------------------------------
  // Storage and pointers
  // --------------------------------------------------------------------
  // DEPTH must be a power of two; pointers wrap naturally
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [ADDR_BITS-1:0] wrPtr_reg;
  reg [ADDR_BITS-1:0] rdPtr_reg;
  reg [ADDR_BITS:0] count_reg;
  wire push;
  wire pop;

  assign inReady = (count_reg != DEPTH[ADDR_BITS:0]);
  assign outValid = (count_reg != {(ADDR_BITS+1){1'b0}});
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign outData = mem[rdPtr_reg];

  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1) begin : gEntry
      localparam [ADDR_BITS-1:0] ENTRY = i;
      always @(posedge clk) begin
        if (!rst_b) begin
          mem[i] <= {WIDTH{1'b0}};
        end else if (push && wrPtr_reg == ENTRY) begin
          mem[i] <= inData;
        end
      end
    end
  endgenerate

  always @(posedge clk) begin
    if (!rst_b || flush) begin
      wrPtr_reg <= {ADDR_BITS{1'b0}};
      rdPtr_reg <= {ADDR_BITS{1'b0}};
      count_reg <= {(ADDR_BITS+1){1'b0}};
    end else begin
      if (push) begin
        wrPtr_reg <= wrPtr_reg + {{(ADDR_BITS-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rdPtr_reg <= rdPtr_reg + {{(ADDR_BITS-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        count_reg <= count_reg + {{ADDR_BITS{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        count_reg <= count_reg - {{ADDR_BITS{1'b0}}, 1'b1};
      end
    end
  end

endmodule // sample_fifo

// ==== tb/modulator_model.sv ====
// Bitstream source standing in for the amplifier and modulator
`timescale 1ns/100ps
module modulator_model (
  input wire clk, // System clock
  input wire ones, // 1 full positive density, 0 full negative
  output reg modulatorBit // Bitstream into the converter
);
  // Driven line, never released, so the level is always defined
  initial modulatorBit = 1'h0;
  always @(posedge clk) begin
    modulatorBit <= ones;
  end
endmodule // modulator_model

// ==== tb/sigma_adc_checker_assertions.sv ====
// Port-level assertions of the converter control block
`timescale 1ns/100ps
`include "adc_ctrl_map.vh"
module sigma_adc_checker (
  input wire clk, // System clock
  input wire rst_b, // Reset, active low
  input wire psel, // APB select
  input wire penable, // APB access
  input wire pwrite, // APB write
  input wire [11:0] paddr, // APB address
  input wire [31:0] pwdata, // APB write data
  input wire [31:0] prdata, // APB read data
  input wire pready, // APB ready
  input wire pslverr, // APB error
  input wire modulatorBit, // Bitstream
  input wire converterEnable, // Enable out
  input wire inputSourceSelect, // Input select out
  input wire referenceSourceSelect, // Reference select out
  input wire internalRefScale, // Scale out
  input wire converterClock // Divided clock
);
  wire acc = psel && penable;
  wire modeWr = acc && pwrite && paddr == {`MODE_INDEX, 2'h0};
  wire divWr = acc && pwrite && paddr == {`DIVISOR_INDEX, 2'h0};
  wire statWr = acc && pwrite && paddr == {`STATUS_INDEX, 2'h0};
  wire statRd = acc && !pwrite && paddr == {`STATUS_INDEX, 2'h0};
  wire lowRd = acc && !pwrite && paddr == {`RESULT_LOW_INDEX, 2'h0};
  reg clkPrev;
  wire tog = converterClock != clkPrev;
  reg [7:0] divReg;
  reg [8:0] halfCnt;
  reg armed;
  reg [7:0] lowLast;
  reg lowSeen;
  reg readySeen;
  // ---------------------------------------------------------------
  // Shadow state
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_b) begin
      divReg <= 8'h00;
      halfCnt <= 9'h000;
      clkPrev <= 1'h0;
      armed <= 1'h0;
      lowLast <= 8'h00;
      lowSeen <= 1'h0;
      readySeen <= 1'h0;
    end else begin
      clkPrev <= converterClock;
      halfCnt <= tog ? 9'h001 : halfCnt + 9'h001;
      if (divWr) divReg <= pwdata[7:0];
      armed <= converterEnable && !divWr && (armed || tog);
      if (lowRd) lowLast <= prdata[7:0];
      lowSeen <= (lowSeen || (lowRd && readySeen)) && !statWr;
      readySeen <= (readySeen || (statRd && prdata[0])) && !statWr;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_clock_idle: assert property (!converterEnable [*2] |-> !converterClock)
    else $error("converter clock runs while disabled");
  a_half_period: assert property (armed && converterEnable && tog |->
    halfCnt == 9'h100 - {1'h0, divReg}) else $error("half period wrong");
  a_enable_write: assert property (modeWr |=>
    converterEnable == $past(pwdata[0])) else $error("enable not written");
  a_select_write: assert property (modeWr |=>
    {internalRefScale, referenceSourceSelect, inputSourceSelect} ==
    $past(pwdata[3:1])) else $error("mode selects not written");
  a_mode_hold: assert property (!modeWr |=> $stable({converterEnable,
    inputSourceSelect, referenceSourceSelect, internalRefScale}))
    else $error("mode outputs changed without write");
  a_result_hold: assert property (lowRd && lowSeen |->
    prdata[7:0] == lowLast) else $error("result changed while ready");
  a_ready_sticky: assert property (statRd && readySeen |-> prdata[0])
    else $error("ready flag dropped without clear");
  a_unmapped_err: assert property (acc && paddr == 12'h000 |->
    pslverr && prdata == 32'h0) else $error("unmapped access not refused");
endmodule // sigma_adc_checker

// ==== tb/sigma_adc_control_regs_bench.sv ====
// Self-checking bench of the converter control block
`timescale 1ns/100ps
`include "adc_ctrl_map.vh"
module sigma_adc_control_regs_bench;
  localparam [11:0] modeAddr = {`MODE_INDEX, 2'h0};
  localparam [11:0] divAddr = {`DIVISOR_INDEX, 2'h0};
  localparam [11:0] statAddr = {`STATUS_INDEX, 2'h0};
  localparam [11:0] lowAddr = {`RESULT_LOW_INDEX, 2'h0};
  localparam [11:0] highAddr = {`RESULT_HIGH_INDEX, 2'h0};
  reg clk = 1'h0;
  reg rst_b = 1'h0;
  reg psel = 1'h0;
  reg penable = 1'h0;
  reg pwrite = 1'h0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  reg ones = 1'h1;
  reg [31:0] rdata;
  reg rerr;
  integer mismatches = 0;
  integer comparisons = 0;
  wire [31:0] prdata;
  wire pready, pslverr, modulatorBit, converterEnable, inputSourceSelect;
  wire referenceSourceSelect, internalRefScale, converterClock;
  sigma_adc_control_regs sigma_adc_control_regs_inst (.clk(clk),
    .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .modulatorBit(modulatorBit),
    .converterEnable(converterEnable), .inputSourceSelect(inputSourceSelect),
    .referenceSourceSelect(referenceSourceSelect),
    .internalRefScale(internalRefScale), .converterClock(converterClock));
  modulator_model modulator_model_inst (.clk(clk), .ones(ones),
    .modulatorBit(modulatorBit));
  initial forever #5 clk = ~clk;
  // ---------------------------------------------------------------
  // Bus and compare tasks
  // ---------------------------------------------------------------
  task check(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge clk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      n = 0;
      @(posedge clk);
      while (pready !== 1'h1) begin
        @(posedge clk);
        n = n + 1;
      end
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
    end
  endtask
  task rd(input [11:0] a, input [31:0] exp);
    begin
      apb(1'h0, a, 32'h0);
      check(rdata, exp);
    end
  endtask
  task print_verdict;
    begin
      $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task t_reset;
    begin
      rd(modeAddr, 32'h0);
      rd(divAddr, 32'h0);
      rd(statAddr, 32'h0);
      rd(lowAddr, 32'h0);
      rd(highAddr, 32'h0);
    end
  endtask
  task t_mode;
    integer i;
    reg [3:0] v;
    begin
      for (i = 0; i < 5; i = i + 1) begin
        v = 4'h1 << i;
        apb(1'h1, modeAddr, {28'h0, v});
        @(negedge clk);
        check({28'h0, internalRefScale, referenceSourceSelect,
          inputSourceSelect, converterEnable}, {28'h0, v});
        rd(modeAddr, {28'h0, v});
      end
    end
  endtask
  task t_err;
    begin
      apb(1'h0, 12'h000, 32'h0);
      check({31'h0, rerr}, 32'h1);
      check(rdata, 32'h0);
      apb(1'h1, lowAddr, 32'hFF);
      rd(lowAddr, 32'h0);
      apb(1'h1, divAddr, 32'hFF);
      rd(divAddr, 32'h0);
    end
  endtask
  task t_convert(input rate, input bit1, input [15:0] exp, input integer early);
    integer n;
    begin
      apb(1'h1, modeAddr, 32'h0);
      apb(1'h1, statAddr, {29'h0, rate, 2'h0});
      ones <= bit1;
      apb(1'h1, divAddr, 32'hFF);
      apb(1'h1, modeAddr, 32'h1);
      repeat (early) @(posedge clk);
      rd(statAddr, {29'h0, rate, 2'h0});
      n = 0;
      while (rdata[0] !== 1'h1 && n < 1000) begin
        apb(1'h0, statAddr, 32'h0);
        n = n + 1;
      end
      check({31'h0, rdata[0]}, 32'h1);
      rd(highAddr, {24'h0, exp[15:8]});
      rd(lowAddr, {24'h0, exp[7:0]});
      rd(lowAddr, {24'h0, exp[7:0]});
      rd(statAddr, {29'h0, rate, 2'h1});
    end
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'h1;
    t_reset;
    t_mode;
    t_err;
    t_convert(1'h0, 1'h1, 16'h7A12, 7500);
    t_convert(1'h0, 1'h0, 16'h85EE, 7500);
    t_convert(1'h1, 1'h1, 16'h7A12, 15500);
    print_verdict;
  end
  initial begin
    repeat (60000) @(posedge clk);
    mismatches = mismatches + 1;
    print_verdict;
  end
endmodule // sigma_adc_control_regs_bench
bind sigma_adc_control_regs sigma_adc_checker sigma_adc_checker_inst (
  .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .modulatorBit(modulatorBit),
  .converterEnable(converterEnable), .inputSourceSelect(inputSourceSelect),
  .referenceSourceSelect(referenceSourceSelect),
  .internalRefScale(internalRefScale), .converterClock(converterClock));
